// [rtl/mwm_defines.svh]
`ifndef MWM_DEFINES_SVH
`define MWM_DEFINES_SVH

// Indexes of the configuration registers
`define MWM_IDX_EXT1A 8'h67
`define MWM_IDX_EXT23 8'h6c
`define MWM_IDX_BASE_PORT 8'h6d
`define MWM_IDX_EXT2 8'h6e
`define MWM_IDX_SETB_CTL 8'h74

// Reset value shared by every register
`define MWM_RST_BYTE 8'h00

// Field positions
`define MWM_BASE_SEL_MSB 7
`define MWM_BASE_SEL_LSB 4
`define MWM_PORT_SEL_MSB 3
`define MWM_PORT_SEL_LSB 0
`define MWM_PAGE_EN_BIT 7
`define MWM_SETB_SEL_A_BIT 1

// Page-0 I/O addresses for the valid port selector codes
`define MWM_PORT_C0 12'h208
`define MWM_PORT_C1 12'h218
`define MWM_PORT_C5 12'h258
`define MWM_PORT_C6 12'h268
`define MWM_PORT_CA 12'h2a8
`define MWM_PORT_CB 12'h2b8
`define MWM_PORT_CE 12'h2e8
`define MWM_SEL_C0 4'h0
`define MWM_SEL_C1 4'h1
`define MWM_SEL_C5 4'h5
`define MWM_SEL_C6 4'h6
`define MWM_SEL_CA 4'ha
`define MWM_SEL_CB 4'hb
`define MWM_SEL_CE 4'he

// 16 Kbyte frame numbers (address bits 23-14) of the window starts
`define MWM_SETA_FRAME0 10'h030
`define MWM_SETB_FRAME0 10'h028

`endif

// [rtl/mwm_pkg.sv]
package mwm_pkg;
    // One page or extension register
    typedef logic [7:0] mwm_byte_t;
    // Which window set an access fell into
    typedef enum logic [1:0] {
        MWM_WIN_NONE,
        MWM_WIN_A,
        MWM_WIN_B
    } mwm_win_t;
endpackage

// [rtl/mwm_page_if.sv]
`timescale 1ns/100ps
interface mwm_page_if;
    import mwm_pkg::*;
    mwm_byte_t page_a [8]; // Set A page registers
    mwm_byte_t page_b [4]; // Set B page registers
    mwm_byte_t ext2_a; // Bits 22-21, set A pages 0-3
    mwm_byte_t ext2_b; // Bits 22-21, set B pages 0-3
    mwm_byte_t ext1_a; // Bits 22-21, set A pages 4-7
    mwm_byte_t ext23; // Bit 23, one bit per set A page; bits 3-0 also serve set B
    logic [3:0] base_sel; // Set A base selector

    modport cfg (output page_a, page_b, ext2_a, ext2_b, ext1_a, ext23,
                 base_sel);
    modport xlat (input page_a, page_b, ext2_a, ext2_b, ext1_a, ext23,
                  base_sel);
endinterface

// [rtl/mwm_xlat.sv]
`timescale 1ns/100ps
`include "mwm_defines.svh"
module mwm_xlat
    import mwm_pkg::*;
(
    mwm_page_if.xlat pif,
    input wire logic [23:0] addr_i,
    output logic [23:0] addr_o,
    output logic hit_o,
    output mwm_win_t win_o
);
    ////////////////////////////////////////////////////////////////////////
    // Window hit detection

    wire [9:0] frame = addr_i[23:14]; // 16 Kbyte frame of the access
    // Set A start moves one frame per selector step
    wire [9:0] a_start = `MWM_SETA_FRAME0 + {6'h00, pif.base_sel};
    wire [9:0] a_off = frame - a_start;
    // Eight adjacent frames from the start
    wire in_a = (a_off[9:3] == 7'h00);
    wire [2:0] a_pg = a_off[2:0];
    // Set B never moves; named so its frame bits can be sliced
    wire [9:0] b_start = `MWM_SETB_FRAME0;
    wire in_b = (frame[9:2] == b_start[9:2]);
    wire [1:0] b_pg = frame[1:0];

    ////////////////////////////////////////////////////////////////////////
    // Translation value and extension bits of the hit page

    wire [7:0] a_reg = pif.page_a[a_pg];
    wire [7:0] b_reg = pif.page_b[b_pg];
    // Pages 4-7 take bits 22-21 from their own register
    wire [7:0] a_ext = a_pg[2] ? pif.ext1_a : pif.ext2_a;
    wire [1:0] a_2221 = a_ext[{a_pg[1:0], 1'b0} +: 2];
    wire [1:0] b_2221 = pif.ext2_b[{b_pg, 1'b0} +: 2];
    // Bit 23 bits 3-0 serve both sets
    wire a_23 = pif.ext23[a_pg];
    wire b_23 = pif.ext23[{1'b0, b_pg}];

    wire a_on = in_a && a_reg[`MWM_PAGE_EN_BIT];
    wire b_on = in_b && b_reg[`MWM_PAGE_EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Output address: frame bits replaced, offset kept

    assign hit_o = a_on || b_on;
    assign win_o = a_on ? MWM_WIN_A : (b_on ? MWM_WIN_B : MWM_WIN_NONE);
    // Disabled or missed pages pass straight through
    assign addr_o = a_on ? {a_23, a_2221, a_reg[6:0], addr_i[13:0]} :
                    b_on ? {b_23, b_2221, b_reg[6:0], addr_i[13:0]} :
                    addr_i;
endmodule

// [rtl/mwm_mapper.sv]
// Functional notes
// - Select register: base selector high, port selector low
// - Select register resets to zero
// - Port selector places both sets' page registers
// - Selector codes give page-0 port, pages 2000h apart
// - Page write stores translated bits 20-14
// - Page bit 7 enables, bits 6-0 translate
// - Base selector moves set A in 4000h steps
// - Set A pages occupy adjacent 16K regions
// - Set B base fixed at 0A0000h
// - Low extension holds bits 22-21, pages 0-3
// - Set-B control bit 1 picks extension copy
// - Control bit 1 set selects set A
// - Set A pages 4-7 use separate extension
// - Bit 23 register, one bit per set A page, bits 3-0 shared with set B
`timescale 1ns/100ps
`include "mwm_defines.svh"
module mwm_mapper
    import mwm_pkg::*;
#(
    parameter logic [15:0] CFG_INDEX_PORT = 16'h0022,
    parameter logic [15:0] CFG_DATA_PORT = 16'h0023
)(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    input wire logic mem_req_i,
    input wire logic [23:0] mem_addr_i,
    output logic [23:0] mem_addr_o,
    output logic mem_valid_o,
    output logic mem_mapped_o,
    output logic mem_set_b_o
);
    ////////////////////////////////////////////////////////////////////////
    // Port selector decode

    // Page-0 port for a selector code; unlisted codes map nothing
    function automatic logic [12:0] port_of(input logic [3:0] sel);
        logic [12:0] r;
        r = 13'h0000;
        case (sel)
            `MWM_SEL_C0: r = {1'b1, `MWM_PORT_C0};
            `MWM_SEL_C1: r = {1'b1, `MWM_PORT_C1};
            `MWM_SEL_C5: r = {1'b1, `MWM_PORT_C5};
            `MWM_SEL_C6: r = {1'b1, `MWM_PORT_C6};
            `MWM_SEL_CA: r = {1'b1, `MWM_PORT_CA};
            `MWM_SEL_CB: r = {1'b1, `MWM_PORT_CB};
            `MWM_SEL_CE: r = {1'b1, `MWM_PORT_CE};
            default: r = 13'h0000;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    mwm_byte_t index_q; // Current configuration index
    mwm_byte_t sel_q; // Base and port selectors
    mwm_byte_t ext2_a_q; // Bits 22-21 copy for set A
    mwm_byte_t ext2_b_q; // Bits 22-21 copy for set B
    mwm_byte_t ext1_a_q; // Bits 22-21 for set A pages 4-7
    mwm_byte_t ext23_q; // Bit 23 for every page
    logic setb_sel_a_q; // Extension copy chooser
    mwm_byte_t page_a_q [8]; // Set A page bank
    mwm_byte_t page_b_q [4]; // Set B page bank
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [23:0] maddr_q;
    logic mvalid_q;
    logic mmapped_q;
    logic mset_b_q;

    ////////////////////////////////////////////////////////////////////////
    // I/O decode

    wire idx_hit = (io_addr_i == CFG_INDEX_PORT);
    wire data_hit = (io_addr_i == CFG_DATA_PORT);
    wire cfg_wr = io_wr_i && data_hit;
    wire wr_sel = cfg_wr && (index_q == `MWM_IDX_BASE_PORT);
    wire wr_ext2 = cfg_wr && (index_q == `MWM_IDX_EXT2);
    wire wr_ext1a = cfg_wr && (index_q == `MWM_IDX_EXT1A);
    wire wr_ext23 = cfg_wr && (index_q == `MWM_IDX_EXT23);
    wire wr_ctl = cfg_wr && (index_q == `MWM_IDX_SETB_CTL);

    // Page port: low 13 bits match page 0, top three bits give the page
    wire [3:0] port_sel = sel_q[`MWM_PORT_SEL_MSB:`MWM_PORT_SEL_LSB];
    wire [12:0] port0 = port_of(port_sel);
    wire pg_addr_ok = port0[12] &&
                      (io_addr_i[12:0] == {1'b0, port0[11:0]});
    wire [2:0] pg_num = io_addr_i[15:13];
    // The data port wins if it ever aliases a page port
    wire pg_hit = pg_addr_ok && !idx_hit && !data_hit;
    // Low pages of the bank follow the copy chooser
    wire pg_to_b = !pg_num[2] && !setb_sel_a_q;
    wire pg_wr_a = io_wr_i && pg_hit && !pg_to_b;
    wire pg_wr_b = io_wr_i && pg_hit && pg_to_b;

    ////////////////////////////////////////////////////////////////////////
    // Read data selection

    wire [7:0] pg_rd = pg_to_b ? page_b_q[pg_num[1:0]] : page_a_q[pg_num];
    wire [7:0] ext2_rd = setb_sel_a_q ? ext2_a_q : ext2_b_q;
    wire [7:0] cfg_rd =
        (index_q == `MWM_IDX_BASE_PORT) ? sel_q :
        (index_q == `MWM_IDX_EXT2) ? ext2_rd :
        (index_q == `MWM_IDX_EXT1A) ? ext1_a_q :
        (index_q == `MWM_IDX_EXT23) ? ext23_q :
        (index_q == `MWM_IDX_SETB_CTL) ?
            {6'h00, setb_sel_a_q, 1'b0} :
        `MWM_RST_BYTE;
    // Unmapped reads return zero
    wire [7:0] rd_data = idx_hit ? index_q :
                         data_hit ? cfg_rd :
                         pg_hit ? pg_rd :
                         `MWM_RST_BYTE;

    ////////////////////////////////////////////////////////////////////////
    // Index register

    // Index write
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            index_q <= `MWM_RST_BYTE;
        end else if (io_wr_i && idx_hit) begin
            index_q <= io_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Window select register, both fields writable
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_q <= `MWM_RST_BYTE;
        end else if (wr_sel) begin
            sel_q <= io_wdata_i;
        end
    end

    // Extension copy chooser, only bit 1 kept
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            setb_sel_a_q <= 1'b0;
        end else if (wr_ctl) begin
            setb_sel_a_q <= io_wdata_i[`MWM_SETB_SEL_A_BIT];
        end
    end

    // Bits 22-21 of pages 0-3, two copies
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext2_a_q <= `MWM_RST_BYTE;
            ext2_b_q <= `MWM_RST_BYTE;
        end else if (wr_ext2 && setb_sel_a_q) begin
            ext2_a_q <= io_wdata_i;
        end else if (wr_ext2) begin
            ext2_b_q <= io_wdata_i;
        end
    end

    // Set A high pages and bit 23; bit 23 is one shared copy, so the
    // chooser does not gate it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext1_a_q <= `MWM_RST_BYTE;
            ext23_q <= `MWM_RST_BYTE;
        end else begin
            if (wr_ext1a) begin
                ext1_a_q <= io_wdata_i;
            end
            if (wr_ext23) begin
                ext23_q <= io_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page register bank

    // Set A pages; selectors are assumed programmed first, otherwise
    // the write lands at whatever port the old selector gave
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 8; i++) begin
                page_a_q[i] <= `MWM_RST_BYTE;
            end
        end else if (pg_wr_a) begin
            page_a_q[pg_num] <= io_wdata_i;
        end
    end

    // Set B pages share ports 0-3 with set A
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 4; i++) begin
                page_b_q[i] <= `MWM_RST_BYTE;
            end
        end else if (pg_wr_b) begin
            page_b_q[pg_num[1:0]] <= io_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read return, one cycle after the strobe

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= `MWM_RST_BYTE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= io_rd_i;
            if (io_rd_i) begin
                rdata_q <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address translation

    mwm_page_if pif ();
    assign pif.page_a = page_a_q;
    assign pif.page_b = page_b_q;
    assign pif.ext2_a = ext2_a_q;
    assign pif.ext2_b = ext2_b_q;
    assign pif.ext1_a = ext1_a_q;
    assign pif.ext23 = ext23_q;
    assign pif.base_sel = sel_q[`MWM_BASE_SEL_MSB:`MWM_BASE_SEL_LSB];

    logic [23:0] xaddr;
    logic xhit;
    mwm_win_t xwin;

    // Extensions are read live, so enabling a page before its
    // extensions are set sends early accesses to the wrong place
    mwm_xlat u_xlat (
        .pif(pif.xlat),
        .addr_i(mem_addr_i),
        .addr_o(xaddr),
        .hit_o(xhit),
        .win_o(xwin)
    );

    // Registered so the outputs come from flops; costs one cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            maddr_q <= 24'h000000;
            mvalid_q <= 1'b0;
            mmapped_q <= 1'b0;
            mset_b_q <= 1'b0;
        end else begin
            mvalid_q <= mem_req_i;
            if (mem_req_i) begin
                maddr_q <= xaddr;
                mmapped_q <= xhit;
                mset_b_q <= (xwin == MWM_WIN_B);
            end
        end
    end

    assign io_rdata_o = rdata_q;
    assign io_rvalid_o = rvalid_q;
    assign mem_addr_o = maddr_q;
    assign mem_valid_o = mvalid_q;
    assign mem_mapped_o = mmapped_q;
    assign mem_set_b_o = mset_b_q;
endmodule

// [verif/mwm_mapper_asserts.sv]
`timescale 1ns/100ps
module mwm_mapper_chk (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rvalid_o,
    input wire logic mem_req_i,
    input wire logic [23:0] mem_addr_i,
    input wire logic [23:0] mem_addr_o,
    input wire logic mem_valid_o,
    input wire logic mem_mapped_o,
    input wire logic mem_set_b_o
);
    // One clock domain, so defaults are declared once
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // Accepted memory request and its answer
    sequence s_acc;
        mem_req_i ##1 mem_valid_o;
    endsequence
    property p_rd_ans;
        io_rd_i |=> io_rvalid_o;
    endproperty
    property p_rd_one;
        !io_rd_i |=> !io_rvalid_o;
    endproperty
    property p_rst_val;
        $rose(nrst_i) |-> io_rdata_o == 8'h00 && mem_addr_o == 24'h000000;
    endproperty
    property p_mem_ans;
        mem_req_i |=> mem_valid_o;
    endproperty
    property p_low;
        s_acc |-> mem_addr_o[13:0] == $past(mem_addr_i[13:0]);
    endproperty
    property p_pass;
        s_acc ##0 !mem_mapped_o |-> mem_addr_o == $past(mem_addr_i);
    endproperty
    property p_setb;
        s_acc ##0 mem_set_b_o |-> $past(mem_addr_i[23:16]) == 8'h0a;
    endproperty
    property p_below;
        mem_req_i && mem_addr_i[23:16] < 8'h0a |=> !mem_mapped_o;
    endproperty
    property p_hold;
        !mem_req_i |=> $stable(mem_addr_o);
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read answer missing");
    a_rd_one: assert property (p_rd_one)
        else $error("read answer without read");
    a_rst_val: assert property (p_rst_val)
        else $error("outputs not zero after reset");
    a_mem_ans: assert property (p_mem_ans)
        else $error("memory answer missing");
    a_low: assert property (p_low)
        else $error("low address bits changed");
    a_pass: assert property (p_pass)
        else $error("unmapped access altered");
    a_setb: assert property (p_setb)
        else $error("set b hit outside fixed base");
    a_below: assert property (p_below)
        else $error("mapped below any window");
    a_hold: assert property (p_hold)
        else $error("address output moved without request");
endmodule

bind mwm_mapper mwm_mapper_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .mem_req_i(mem_req_i),
    .mem_addr_i(mem_addr_i), .mem_addr_o(mem_addr_o),
    .mem_valid_o(mem_valid_o), .mem_mapped_o(mem_mapped_o),
    .mem_set_b_o(mem_set_b_o));

// [verif/mwm_cpu_model.sv]
`timescale 1ns/100ps
module mwm_cpu_model (
    input wire logic clk_i,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [15:0] io_addr_o,
    output logic [7:0] io_wdata_o,
    input wire logic [7:0] io_rdata_i,
    output logic mem_req_o,
    output logic [23:0] mem_addr_o,
    input wire logic [23:0] mem_xaddr_i,
    input wire logic mem_mapped_i,
    input wire logic mem_set_b_i
);
    // Idle bus at time zero
    initial begin
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_addr_o = 16'h0000;
        io_wdata_o = 8'h00;
        mem_req_o = 1'b0;
        mem_addr_o = 24'h000000;
    end
    ////////////////////////////////////////////////////////////////////
    // One write cycle; released lines flip so stale values never match
    task automatic io_w(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i) #1;
        io_wr_o = 1'b1;
        io_addr_o = a;
        io_wdata_o = d;
        @(posedge clk_i) #1;
        io_wr_o = 1'b0;
        io_addr_o = ~a;
        io_wdata_o = ~d;
    endtask
    // One read cycle; data taken when the answer stands
    task automatic io_r(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i) #1;
        io_rd_o = 1'b1;
        io_addr_o = a;
        @(posedge clk_i) #1;
        io_rd_o = 1'b0;
        io_addr_o = ~a;
        d = io_rdata_i;
    endtask
    // Indexed access: index port goes first, then data port
    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
        io_w(16'h0022, idx);
        io_w(16'h0023, d);
    endtask
    task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d);
        io_w(16'h0022, idx);
        io_r(16'h0023, d);
    endtask
    // One memory access; extensions are set before enables
    task automatic mem(input logic [23:0] a, output logic [23:0] o,
                       output logic m, output logic b);
        @(posedge clk_i) #1;
        mem_req_o = 1'b1;
        mem_addr_o = a;
        @(posedge clk_i) #1;
        mem_req_o = 1'b0;
        mem_addr_o = ~a;
        o = mem_xaddr_i;
        m = mem_mapped_i;
        b = mem_set_b_i;
    endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top import mwm_pkg::*;;
    localparam logic [3:0] CODES [7] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'ha,
                                        4'hb, 4'he};
    localparam logic [11:0] PORTS [7] = '{12'h208, 12'h218, 12'h258,
        12'h268, 12'h2a8, 12'h2b8, 12'h2e8};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic io_wr, io_rd, io_rvalid, mem_req, mem_valid, mem_mapped, mem_b;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata;
    logic [23:0] mem_addr, mem_x;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    mwm_mapper dut (.clk_i(clk), .nrst_i(nrst), .io_wr_i(io_wr),
        .io_rd_i(io_rd), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
        .io_rdata_o(io_rdata), .io_rvalid_o(io_rvalid),
        .mem_req_i(mem_req), .mem_addr_i(mem_addr), .mem_addr_o(mem_x),
        .mem_valid_o(mem_valid), .mem_mapped_o(mem_mapped),
        .mem_set_b_o(mem_b));
    mwm_cpu_model cpu (.clk_i(clk), .io_wr_o(io_wr), .io_rd_o(io_rd),
        .io_addr_o(io_addr), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata),
        .mem_req_o(mem_req), .mem_addr_o(mem_addr), .mem_xaddr_i(mem_x),
        .mem_mapped_i(mem_mapped), .mem_set_b_i(mem_b));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] pa(input int n, input logic [11:0] p);
        return {n[2:0], 1'b0, p};
    endfunction
    // Expected output: enabled page swaps bits 23-14
    function automatic logic [23:0] exp_x(input logic [23:0] a,
            input mwm_byte_t pg, ex, e, input int n);
        int k = 2 * (n % 4);
        return pg[7] ? {e[n], ex[k+1], ex[k], pg[6:0], a[13:0]} : a;
    endfunction
    task automatic chk(input string nm, input logic [23:0] e, g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        mwm_byte_t d, pg, ex, e23, exa, sel;
        logic [23:0] a, o;
        logic m, sb;
        logic [3:0] b;
        int n;
        r = 32'h043d;
        exa = 8'h00;
        e23 = 8'h00;
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        cpu.cfg_rd(8'h6d, d);
        chk("select reset", 8'h00, d);
        cpu.cfg_rd(8'h6e, d);
        chk("ext reset", 8'h00, d);
        // Every valid port selector code, every page port
        foreach (CODES[i]) begin
            r = lfsr(r);
            sel = {r[7:4], CODES[i]};
            cpu.cfg_wr(8'h6d, sel);
            cpu.cfg_rd(8'h6d, d);
            chk("select", sel, d);
            for (int j = 0; j < 8; j++) begin
                r = lfsr(r);
                cpu.io_w(pa(j, PORTS[i]), r[15:8]);
                cpu.io_r(pa(j, PORTS[i]), d);
                chk("page", r[15:8], d);
            end
        end
        // Unlisted selector code leaves no page port behind
        cpu.cfg_wr(8'h6d, 8'h02);
        cpu.io_w(16'h0208, 8'h5a);
        cpu.io_r(16'h0208, d);
        chk("unlisted code", 8'h00, d);
        // Set A translation, top base and disabled page among them
        cpu.cfg_wr(8'h74, 8'h02);
        for (int i = 0; i < 12; i++) begin
            r = lfsr(lfsr(r));
            b = (i == 0) ? 4'hf : r[3:0];
            n = (i == 0) ? 7 : int'(r[6:4]);
            pg = {(i != 1) && r[7], r[14:8]};
            ex = r[23:16];
            e23 = r[31:24];
            cpu.cfg_wr(8'h6d, {b, 4'h0});
            cpu.cfg_wr((n < 4) ? 8'h6e : 8'h67, ex);
            cpu.cfg_wr(8'h6c, e23);
            cpu.io_w(pa(n, 12'h208), pg);
            if (n < 4) exa = ex;
            a = {10'h030 + 10'(b) + 10'(n), r[13:0]};
            cpu.mem(a, o, m, sb);
            chk("xlat a", exp_x(a, pg, ex, e23, n), o);
            chk("mapped a", pg[7], m);
        end
        // Set B at its fixed base, own extension copy
        cpu.cfg_wr(8'h74, 8'h00);
        for (int j = 0; j < 4; j++) begin
            r = lfsr(lfsr(r));
            pg = {1'b1, r[6:0]};
            ex = r[15:8];
            cpu.cfg_wr(8'h6e, ex);
            cpu.io_w(pa(j, 12'h208), pg);
            a = {10'h028 + 10'(j), r[29:16]};
            cpu.mem(a, o, m, sb);
            chk("xlat b", exp_x(a, pg, ex, e23, j), o);
            chk("set b", 1'b1, sb);
        end
        cpu.cfg_wr(8'h74, 8'h02);
        cpu.cfg_rd(8'h74, d);
        chk("chooser", 8'h02, d);
        cpu.cfg_rd(8'h6e, d);
        chk("ext copy a", exa, d);
        cpu.mem(24'h012345, o, m, sb);
        chk("outside", 24'h012345, o);
        results();
    end
endmodule
